//--- verilog/bsc_pkg.sv
// bsc_pkg: constants for the buck supervisory control block
// assumes a 100 MHz core clock; register map sits behind AXI4-Lite
package bsc_pkg;
	// register byte offsets
	localparam logic [7:0] BSC_CTRL_OFS = 8'h00;
	localparam logic [7:0] BSC_STAT_OFS = 8'h04;
	localparam logic [7:0] BSC_OFFT_OFS = 8'h08;
	// control fields
	localparam int BSC_CTRL_PREBIAS_BIT = 0;
	localparam int BSC_CTRL_BRAKE_EN_BIT = 1;
	// status fields
	localparam int BSC_STAT_GDHI_BIT = 0;
	localparam int BSC_STAT_PG_BIT = 1;
	localparam int BSC_STAT_OVTRIP_BIT = 2;
	localparam int BSC_STAT_HSLATCH_BIT = 3;
	localparam int BSC_STAT_BRAKE_BIT = 4;
	localparam int BSC_STAT_ZC_LSB = 8;
	// reset values
	localparam logic [1:0] BSC_CTRL_RST = 2'h2;
	localparam logic [7:0] BSC_OFFT_RST = 8'h0a;
	// zero-crossing run length before low gate-drive level
	localparam int BSC_ZC_RUN = 256;
	// overvoltage qualify delay
	localparam int BSC_CLK_MHZ = 100;
	localparam int BSC_OV_DELAY_NS = 2500;
	localparam int BSC_OV_DELAY_CYC = (BSC_OV_DELAY_NS * BSC_CLK_MHZ) / 1000;
	// axi responses
	localparam logic [1:0] BSC_RESP_OKAY = 2'h0;
	localparam logic [1:0] BSC_RESP_SLVERR = 2'h2;
endpackage : bsc_pkg

//--- verilog/bsc_top.sv
// bsc_top: gate-drive level choice, power-good window, overvoltage latch,
// freewheel braking and minimum off-time for a synchronous buck stage
// assumes comparator and pin inputs are asynchronous; aresetn is supply cycling
// Overview of operation
// - turn-on starts gate drive at high level
// - sample zero-cross at low-side drive falling edge
// - 256 consecutive crossings select low level
// - missed crossing clears count, high level
// - bias only, enable low: low level
// - power good high only inside window
// - falling threshold gives lower-side hysteresis
// - power good is open drain
// - enable low forces power good low
// - overvoltage trips after 2.5 us qualify
// - trip latches high side off, pg low
// - low side on while overvoltage persists
// - high side latch cleared only by reset
// - overvoltage watch active regardless of enable
// - skipped pulse enters braking, low side off
// - no braking during pre-biased start-up
// - overvoltage trip overrides braking, low side on
// - minimum off-time each period limits duty
// - enable low turns both drives off unless an overvoltage trip holds low side on
`timescale 1ns/100ps
module bsc_top
	import bsc_pkg::*;
#(
	parameter int ZC_RUN = BSC_ZC_RUN,
	parameter int OV_DELAY_CYC = BSC_OV_DELAY_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic enable_in,
	input wire logic bias_present,
	input wire logic pwm_in,
	input wire logic period_start,
	input wire logic zero_cross_cmp,
	input wire logic sense_above_ov,
	input wire logic sense_above_pg_rise,
	input wire logic sense_above_pg_fall,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic high_side_drive,
	output logic low_side_drive,
	output logic gate_drive_high_sel,
	output logic power_good_flag_o,
	output logic power_good_flag_oe
);
	localparam int NSYNC = 8;
	localparam int ZW = $clog2(ZC_RUN + 1);
	localparam int OW = $clog2(OV_DELAY_CYC + 1);

	// three-stage synchronisers; a change counts when stages two and three agree
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] s1;
	logic [NSYNC-1:0] s2;
	logic [NSYNC-1:0] s3;
	logic [NSYNC-1:0] clean;
	assign raw_in = {bias_present, pwm_in, period_start, zero_cross_cmp,
		sense_above_ov, sense_above_pg_rise, sense_above_pg_fall, enable_in};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			clean <= '0;
		end else if (clk_en) begin
			s1 <= raw_in;
			s2 <= s1;
			s3 <= s2;
			clean <= (s2 & s3) | (clean & (s2 | s3));
		end
	end
	logic en_s, pgf_s, pgr_s, ov_s, zc_s, per_s, pwm_s, bias_s;
	assign {bias_s, pwm_s, per_s, zc_s, ov_s, pgr_s, pgf_s, en_s} = clean;

	// register file
	logic [1:0] ctrl;
	logic [7:0] off_cycles;
	logic prebias;
	logic brake_en;
	assign prebias = ctrl[BSC_CTRL_PREBIAS_BIT];
	assign brake_en = ctrl[BSC_CTRL_BRAKE_EN_BIT];

	// edge history for period start and low-side falling edge
	logic per_d;
	logic ls_d;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			per_d <= 1'b0;
			ls_d <= 1'b0;
		end else if (clk_en) begin
			per_d <= per_s;
			ls_d <= low_side_drive;
		end
	end
	logic per_rise;
	logic ls_fall;
	assign per_rise = per_s & ~per_d;
	assign ls_fall = ls_d & ~low_side_drive;

	// zero-crossing run counter and gate-drive level
	logic [ZW-1:0] zc_count;
	logic en_d;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			zc_count <= '0;
			gate_drive_high_sel <= 1'b1;
			en_d <= 1'b0;
		end else if (clk_en) begin
			en_d <= en_s;
			if (!en_s) begin
				zc_count <= '0;
				gate_drive_high_sel <= !bias_s;
			end else if (!en_d) begin
				zc_count <= '0;
				gate_drive_high_sel <= 1'b1;
			end else if (ls_fall) begin
				if (!zc_s) begin
					zc_count <= '0;
					gate_drive_high_sel <= 1'b1;
				end else if (zc_count == ZW'(ZC_RUN - 1)) begin
					zc_count <= ZW'(ZC_RUN);
					gate_drive_high_sel <= 1'b0;
				end else if (zc_count != ZW'(ZC_RUN)) begin
					zc_count <= zc_count + 1'b1;
				end
			end
		end
	end

	// overvoltage qualify timer and high-side latch, independent of enable
	logic [OW-1:0] ov_timer;
	logic ov_trip;
	logic hs_latch;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ov_timer <= '0;
			ov_trip <= 1'b0;
			hs_latch <= 1'b0;
		end else if (clk_en) begin
			if (!ov_s) begin
				ov_timer <= '0;
				ov_trip <= 1'b0;
			end else if (ov_timer == OW'(OV_DELAY_CYC - 1)) begin
				ov_trip <= 1'b1;
				hs_latch <= 1'b1;
			end else begin
				ov_timer <= ov_timer + 1'b1;
			end
		end
	end

	// power-good window with hysteresis on the lower threshold
	logic pg_state;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pg_state <= 1'b0;
		end else if (clk_en) begin
			if (!en_s || ov_trip || ov_s) begin
				pg_state <= 1'b0;
			end else if (!pg_state && pgr_s) begin
				pg_state <= 1'b1;
			end else if (pg_state && !pgf_s) begin
				pg_state <= 1'b0;
			end
		end
	end

	// braking: a period start with pwm low is a skipped pulse
	logic braking;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			braking <= 1'b0;
		end else if (clk_en) begin
			if (!en_s || prebias || !brake_en || pwm_s) begin
				braking <= 1'b0;
			end else if (per_rise && !pwm_s) begin
				braking <= 1'b1;
			end
		end
	end

	// off-time counter: high side blocked for off_cycles after each period start
	logic [7:0] off_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			off_cnt <= '0;
		end else if (clk_en) begin
			if (per_rise) begin
				off_cnt <= off_cycles;
			end else if (off_cnt != 8'h00) begin
				off_cnt <= off_cnt - 1'b1;
			end
		end
	end
	// off-time taken at period start; the window includes the period-start cycle itself
	logic in_off;
	assign in_off = (off_cnt != 8'h00) || per_rise;

	// drive outputs registered; overvoltage beats enable and braking
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_side_drive <= 1'b0;
			low_side_drive <= 1'b0;
			power_good_flag_o <= 1'b0;
			power_good_flag_oe <= 1'b1;
		end else if (clk_en) begin
			power_good_flag_o <= 1'b0;
			power_good_flag_oe <= !pg_state;
			if (ov_trip) begin
				high_side_drive <= 1'b0;
				low_side_drive <= 1'b1;
			end else if (!en_s) begin
				high_side_drive <= 1'b0;
				low_side_drive <= 1'b0;
			end else begin
				high_side_drive <= pwm_s && !hs_latch && !in_off;
				low_side_drive <= !pwm_s && !braking;
			end
		end
	end

	// axi4-lite slave: one write and one read at a time
	logic aw_got, w_got;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= BSC_RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			ctrl <= BSC_CTRL_RST;
			off_cycles <= BSC_OFFT_RST;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr[7:0];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_got && w_got && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= BSC_RESP_OKAY;
				if (aw_addr == BSC_CTRL_OFS) begin
					if (w_strb[0]) ctrl <= w_data[1:0];
				end else if (aw_addr == BSC_OFFT_OFS) begin
					if (w_strb[0]) off_cycles <= w_data[7:0];
				end else if (aw_addr != BSC_STAT_OFS) begin
					s_axi_bresp <= BSC_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read channel; status shows live block state
	logic [31:0] stat_word;
	always_comb begin
		stat_word = '0;
		stat_word[BSC_STAT_GDHI_BIT] = gate_drive_high_sel;
		stat_word[BSC_STAT_PG_BIT] = pg_state;
		stat_word[BSC_STAT_OVTRIP_BIT] = ov_trip;
		stat_word[BSC_STAT_HSLATCH_BIT] = hs_latch;
		stat_word[BSC_STAT_BRAKE_BIT] = braking;
		stat_word[BSC_STAT_ZC_LSB +: 9] = 9'(zc_count);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= BSC_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= BSC_RESP_OKAY;
				case (s_axi_araddr[7:0])
					BSC_CTRL_OFS: s_axi_rdata <= {30'h0000_0000, ctrl};
					BSC_STAT_OFS: s_axi_rdata <= stat_word;
					BSC_OFFT_OFS: s_axi_rdata <= {24'h00_0000, off_cycles};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= BSC_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// checks: gate-drive level choice
	gd_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && en_s && !en_d |=> gate_drive_high_sel)
		else $error("turn-on did not select high level");
	gd_bias_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && !en_s && bias_s |=> !gate_drive_high_sel)
		else $error("bias-only idle not at low level");
	zc_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && en_s && en_d && ls_fall && zc_s && zc_count == ZW'(ZC_RUN - 1)
		|=> !gate_drive_high_sel)
		else $error("full crossing run kept high level");
	zc_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && en_s && en_d && ls_fall && !zc_s |=> gate_drive_high_sel && zc_count == '0)
		else $error("missed crossing kept low level");
	// checks: power-good window and pin
	pg_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && !pg_state && !pgr_s |=> !pg_state)
		else $error("power good rose below rising threshold");
	pg_hyst_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && en_s && !ov_s && !ov_trip && pg_state && pgf_s |=> pg_state)
		else $error("power good dropped inside hysteresis band");
	pg_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && !en_s |=> !pg_state)
		else $error("power good with enable low");
	pg_od_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!power_good_flag_o)
		else $error("power good driven high");
	// checks: overvoltage trip and high-side latch
	ov_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(ov_trip) |-> $past(ov_s) && ov_timer == OW'(OV_DELAY_CYC - 1))
		else $error("trip before qualify delay");
	ov_hs_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && ov_trip |=> !high_side_drive)
		else $error("high side on after trip");
	ov_ls_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && ov_trip |=> low_side_drive)
		else $error("low side off during trip");
	latch_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hs_latch |=> hs_latch)
		else $error("high side latch cleared");
	// checks: braking, off-time and shutdown
	brake_ls_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && en_s && !ov_trip && braking |=> !low_side_drive)
		else $error("low side on while braking");
	brake_pb_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && prebias |=> !braking)
		else $error("braking in pre-bias");
	off_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && !ov_trip && in_off |=> !high_side_drive)
		else $error("high side on inside off-time");
	shut_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && !en_s && !ov_trip |=> !high_side_drive && !low_side_drive)
		else $error("drive during shutdown");
endmodule : bsc_top

//--- test/bsc_pwr_model.sv
// bsc_pwr_model: output sense comparators and the power-good pull-up
// assumes the bench sets an output level code and a light-load flag
`timescale 1ns/100ps
module bsc_pwr_model (
	input wire logic [1:0] lvl,
	input wire logic light,
	input wire logic pg_o,
	input wire logic pg_oe,
	output logic zc,
	output logic ov,
	output logic rise,
	output logic fall,
	output logic pg_pin
);
	// level 0 low, 1 in hysteresis band, 2 in window, 3 over trip
	assign fall = lvl >= 2'h1;
	assign rise = lvl >= 2'h2;
	assign ov = lvl == 2'h3;
	// current dips below zero only at light load
	assign zc = light;
	// external pull-up, so a released pin reads high
	assign pg_pin = pg_oe ? pg_o : 1'h1;
endmodule : bsc_pwr_model

//--- test/bsc_top_tb.sv
// bsc_top_tb: registers, power good, gate-drive level, overvoltage, braking
// assumes bsc_top with shortened counts and bsc_pwr_model beside it
`timescale 1ns/100ps
module bsc_top_tb;
	import bsc_pkg::*;
	localparam int ZR = 4;
	localparam int OD = 5;
	localparam int HS = 3;
	localparam int LS = 2;
	localparam int GD = 1;
	localparam int PG = 0;
	logic aclk, aresetn = 1'h0, enable_in = 1'h0, bias = 1'h1, pwm = 1'h0, pstart = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, light = 1'h0;
	logic [1:0] lvl = 2'h0, bresp, rresp;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
	logic awready, wready, bvalid, arready, rvalid, zc, ov, rise, fall;
	logic hs, ls, gd, pg_o, pg_oe, pg_pin;
	logic [3:0] obs;
	int n, n_mismatch, checks_done, cycles;
	assign obs = {hs, ls, gd, pg_pin};
	bsc_top #(.ZC_RUN(ZR), .OV_DELAY_CYC(OD)) dut (
		.aclk(aclk), .aresetn(aresetn), .clk_en(1'h1), .enable_in(enable_in),
		.bias_present(bias), .pwm_in(pwm), .period_start(pstart), .zero_cross_cmp(zc),
		.sense_above_ov(ov), .sense_above_pg_rise(rise), .sense_above_pg_fall(fall),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
		.high_side_drive(hs), .low_side_drive(ls), .gate_drive_high_sel(gd),
		.power_good_flag_o(pg_o), .power_good_flag_oe(pg_oe));
	bsc_pwr_model pm (.lvl(lvl), .light(light), .pg_o(pg_o), .pg_oe(pg_oe), .zc(zc),
		.ov(ov), .rise(rise), .fall(fall), .pg_pin(pg_pin));
	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	// hang guard: the sequence needs a few hundred cycles
	always @(posedge aclk) begin
		cycles++;
		if (cycles >= 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask : cyc
	// bounded wait for one observed output, then compare it
	task automatic wt(input int i, input logic v, input int lim);
		n = 0;
		while (obs[i] !== v && n < lim) begin
			@(posedge aclk);
			n++;
		end
		chk(obs[i], v, "output level");
	endtask : wt
	task automatic rst();
		aresetn <= 1'h0;
		cyc(16);
		chk({hs, ls, pg_oe, gd}, 4'h3, "reset state");
		aresetn <= 1'h1;
	endtask : rst
	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic aw, w;
		@(posedge aclk);
		aw = 1'h1;
		w = 1'h1;
		awaddr <= {24'h00_0000, a};
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		// no local limit: only the hang guard ends a stuck bus
		while (aw || w || !bvalid) begin
			@(posedge aclk);
			aw = aw && !awready;
			w = w && !wready;
			awvalid <= aw;
			wvalid <= w;
		end
		chk(bresp, er, "bresp");
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge aclk);
		araddr <= {24'h00_0000, a};
		arvalid <= 1'h1;
		@(posedge aclk);
		while (!arready) begin
			@(posedge aclk);
		end
		arvalid <= 1'h0;
		while (!rvalid) begin
			@(posedge aclk);
		end
		d = rdata;
		chk(rresp, er, "rresp");
	endtask : rd
	// switching periods with the off portion first, so every period is skipped at start
	task automatic per(input int k);
		repeat (k) begin
			pstart <= 1'h1;
			cyc(4);
			pstart <= 1'h0;
			cyc(16);
			pwm <= 1'h1;
			cyc(10);
			pwm <= 1'h0;
			cyc(10);
		end
	endtask : per
	initial begin
		rst();
		wt(GD, 1'h0, 20);
		bias <= 1'h0;
		wt(GD, 1'h1, 20);
		bias <= 1'h1;
		rd(BSC_CTRL_OFS, BSC_RESP_OKAY);
		chk(d, {30'h0, BSC_CTRL_RST}, "ctrl reset");
		rd(BSC_OFFT_OFS, BSC_RESP_OKAY);
		chk(d, {24'h00_0000, BSC_OFFT_RST}, "offt reset");
		rd(8'h0c, BSC_RESP_SLVERR);
		chk(d, 32'h0, "unmapped data");
		wr(8'h0c, 32'h0000_0001, BSC_RESP_SLVERR);
		wr(BSC_STAT_OFS, 32'hffff_ffff, BSC_RESP_OKAY);
		wr(BSC_OFFT_OFS, 32'h0000_000c, BSC_RESP_OKAY);
		wr(BSC_CTRL_OFS, 32'h0, BSC_RESP_OKAY);
		enable_in <= 1'h1;
		wt(GD, 1'h1, 20);
		lvl <= 2'h2;
		wt(PG, 1'h1, 20);
		lvl <= 2'h1;
		cyc(10);
		chk(pg_pin, 1'h1, "pg in band");
		lvl <= 2'h0;
		wt(PG, 1'h0, 20);
		lvl <= 2'h1;
		cyc(10);
		chk(pg_pin, 1'h0, "pg below rise");
		lvl <= 2'h2;
		wt(PG, 1'h1, 20);
		enable_in <= 1'h0;
		wt(PG, 1'h0, 20);
		wt(LS, 1'h0, 20);
		enable_in <= 1'h1;
		light <= 1'h1;
		per(ZR - 1);
		chk(gd, 1'h1, "gd early");
		per(1);
		chk(gd, 1'h0, "gd low");
		light <= 1'h0;
		per(1);
		chk(gd, 1'h1, "gd back");
		pwm <= 1'h1;
		wt(HS, 1'h1, 20);
		pstart <= 1'h1;
		wt(HS, 1'h0, 12);
		wt(HS, 1'h1, 30);
		chk(n >= 10 && n <= 14, 1'h1, "off time");
		pstart <= 1'h0;
		pwm <= 1'h0;
		wr(BSC_CTRL_OFS, 32'h0000_0002, BSC_RESP_OKAY);
		wt(LS, 1'h1, 20);
		pstart <= 1'h1;
		wt(LS, 1'h0, 20);
		pwm <= 1'h1;
		cyc(8);
		pwm <= 1'h0;
		wt(LS, 1'h1, 20);
		pstart <= 1'h0;
		wr(BSC_CTRL_OFS, 32'h0000_0003, BSC_RESP_OKAY);
		pstart <= 1'h1;
		cyc(12);
		chk(ls, 1'h1, "no brake prebias");
		pstart <= 1'h0;
		wr(BSC_CTRL_OFS, 32'h0000_0002, BSC_RESP_OKAY);
		pstart <= 1'h1;
		wt(LS, 1'h0, 20);
		lvl <= 2'h3;
		wt(LS, 1'h1, 30);
		pstart <= 1'h0;
		lvl <= 2'h2;
		rst();
		pwm <= 1'h1;
		wt(HS, 1'h1, 30);
		lvl <= 2'h3;
		cyc(3);
		lvl <= 2'h2;
		cyc(15);
		chk(hs, 1'h1, "short overshoot");
		lvl <= 2'h3;
		wt(HS, 1'h0, 40);
		chk(n >= OD && n <= OD + 9, 1'h1, "trip delay");
		chk(pg_pin, 1'h0, "pg on trip");
		chk(ls, 1'h1, "ls on trip");
		lvl <= 2'h2;
		wt(LS, 1'h0, 20);
		enable_in <= 1'h0;
		cyc(10);
		enable_in <= 1'h1;
		cyc(20);
		chk(hs, 1'h0, "latch held");
		rd(BSC_STAT_OFS, BSC_RESP_OKAY);
		chk(d[BSC_STAT_HSLATCH_BIT], 1'h1, "latch bit");
		enable_in <= 1'h0;
		rst();
		lvl <= 2'h3;
		cyc(30);
		lvl <= 2'h2;
		enable_in <= 1'h1;
		cyc(30);
		chk(hs, 1'h0, "latch from idle");
		report_and_stop();
	end
endmodule : bsc_top_tb
